// File: bench/power_mode_sequencer_assertions.sv
// Port-level checks for the power mode sequencer
`timescale 1ns/1ps

module power_mode_sequencer_checker (
  input wire logic       clk_sys,          // Clock
  input wire logic       arst_n,           // Reset, active low
  input wire logic       s_axi_arvalid,    // Read address valid
  input wire logic       s_axi_arready,    // Read address ready
  input wire logic       s_axi_rvalid,     // Read data valid
  input wire logic       wakeup,           // Wakeup level
  input wire logic       reset_req,        // Reset request
  input wire logic       pll_enable,       // PLL powered
  input wire logic       pll_bypass,       // PLL bypassed
  input wire logic [5:0] pll_mult,         // Applied multiplier
  input wire logic       core_clk_en,      // Core clock gate
  input wire logic       sys_clk_en,       // System clock gate
  input wire logic       core_power_on,    // Regulator on
  input wire logic       regulator_bypass, // Regulator bypassed
  input wire logic       dma_l1l2_en,      // On-chip DMA
  input wire logic       dma_ext_en,       // External DMA
  input wire logic       async_periph_en,  // Async access
  input wire logic       pins_hiz,         // Pins three-state
  input wire logic       boot_start        // Boot pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Mode decode; the supply-off test skips an external supply
  wire in_full  = pll_enable && !pll_bypass && core_clk_en;
  wire in_sleep = !core_clk_en && sys_clk_en;
  wire in_deep  = !sys_clk_en && core_power_on && !pins_hiz;
  wire in_off   = !core_power_on && !regulator_bypass;

  property p_full;
    in_full |-> sys_clk_en && core_power_on && !pins_hiz && dma_l1l2_en;
  endproperty
  a_full: assert property (p_full) else $error("full speed outputs wrong");
  property p_bypass;
    pll_bypass && core_clk_en |-> sys_clk_en && core_power_on && dma_l1l2_en;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass outputs wrong");
  property p_mult;
    $changed(pll_mult) |-> in_full;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier moved outside full");
  property p_sleep;
    in_sleep |-> pll_enable && dma_ext_en && !dma_l1l2_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  property p_wake;
    in_sleep && (wakeup || reset_req) |-> ##[1:2] core_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no resume from sleep");
  property p_deep;
    in_deep |-> !pll_enable && !core_clk_en && !async_periph_en;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep outputs wrong");
  property p_deep_stay;
    in_deep && !reset_req && !$past(reset_req) |=> in_deep;
  endproperty
  a_deep_stay: assert property (p_deep_stay) else $error("deep sleep left early");
  property p_off;
    in_off |-> pins_hiz && !core_clk_en && !sys_clk_en;
  endproperty
  a_off: assert property (p_off) else $error("supply off outputs wrong");
  property p_restart;
    in_off && reset_req |-> ##[1:2] (core_power_on && pins_hiz);
  endproperty
  a_restart: assert property (p_restart) else $error("no regulator restart");
  property p_boot;
    boot_start |-> $past(pins_hiz) && !pins_hiz ##1 !boot_start;
  endproperty
  a_boot: assert property (p_boot) else $error("boot pulse misplaced");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule

bind power_mode_sequencer power_mode_sequencer_checker u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .wakeup(wakeup),
  .reset_req(reset_req), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
  .pll_mult(pll_mult), .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en),
  .core_power_on(core_power_on), .regulator_bypass(regulator_bypass),
  .dma_l1l2_en(dma_l1l2_en), .dma_ext_en(dma_ext_en),
  .async_periph_en(async_periph_en), .pins_hiz(pins_hiz), .boot_start(boot_start)
);

// File: bench/tb_top.sv
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ps
`include "pwr_consts.svh"

module tb_top import pwr_pkg::*;;
  logic clk_sys = 1'h0, arst_n = 1'h0, wakeup = 1'h0, reset_req = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF; // Whole words only
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic pll_enable, pll_bypass, core_clk_en, sys_clk_en, core_power_on, regulator_bypass;
  logic dma_l1l2_en, dma_ext_en, async_periph_en, pins_hiz, boot_start;
  logic [5:0] pll_mult;
  logic [3:0] vcore_level;
  logic [31:0] seed = 32'h0001536E; // 86894
  int n_errors = 0;
  int cmp_count = 0;

  power_mode_sequencer DUT (.*);

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected {pll_enable, core_clk_en, sys_clk_en, core_power_on, pins_hiz}
  function automatic logic [4:0] exp_out(input logic [2:0] m, input logic pd);
    case (m)
      3'h0:    return 5'h1E;
      3'h1:    return {~pd, 4'hE};
      3'h2:    return 5'h16;
      3'h3:    return 5'h02;
      default: return 5'h01;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(er), "bresp");
  endtask

  // Read and compare data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask

  // Outputs and status against the expected mode
  task automatic chk_mode(input logic [2:0] m, input logic pd, input logic rf, input logic [5:0] mu);
    #1;
    chk(32'({pll_enable, core_clk_en, sys_clk_en, core_power_on, pins_hiz}), 32'(exp_out(m, pd)), "outs");
    rdc(`OFF_STAT, {18'h0, mu, 3'h0, rf, 1'h0, m}, `RESP_OKAY);
  endtask

  // One-cycle wakeup or reset request, then settle
  task automatic pulse(input logic rst);
    @(posedge clk_sys);
    if (rst) reset_req <= 1'h1;
    else wakeup <= 1'h1;
    @(posedge clk_sys);
    reset_req <= 1'h0;
    wakeup <= 1'h0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well beyond the restart wait
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    $display("[FAIL] %0t watchdog", $time);
    test_done();
  end

  initial begin
    logic [31:0] r;
    logic [5:0]  m;
    int          n;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'h1;
    chk_mode(3'h0, 1'h0, 1'h0, 6'h0A);
    rdc(`OFF_PLL, 32'h00000A00, `RESP_OKAY);
    rdc(`OFF_VREG, 32'h00000093, `RESP_OKAY);
    rdc(`OFF_MODE, 32'h0, `RESP_OKAY);
    rdc(8'h10, 32'h0, `RESP_SLVERR);
    axi_wr(8'h10, 32'hFFFFFFFF, `RESP_SLVERR);
    axi_wr(`OFF_STAT, 32'hFFFFFFFF, `RESP_OKAY);
    chk_mode(3'h0, 1'h0, 1'h0, 6'h0A);
    $display("test reset done");
    repeat (4) begin
      r = rnd();
      axi_wr(`OFF_VREG, {23'h0, r[8], r[7:4], 4'h3}, `RESP_OKAY);
      #1;
      chk(32'({regulator_bypass, vcore_level}), 32'({r[8], r[7:4]}), "vreg");
    end
    axi_wr(`OFF_VREG, 32'h00000093, `RESP_OKAY);
    $display("test regulator done");
    r = rnd();
    m = {r[5:1], 1'h1}; // Odd, so never the reset value
    axi_wr(`OFF_MODE, 32'(`REQ_BYPASS), `RESP_OKAY);
    chk_mode(3'h1, 1'h0, 1'h0, 6'h0A);
    chk(32'({pll_bypass, dma_l1l2_en}), 32'h3, "bypass");
    axi_wr(`OFF_PLL, {18'h0, m, 8'h01}, `RESP_OKAY);
    chk_mode(3'h1, 1'h1, 1'h0, 6'h0A);
    axi_wr(`OFF_MODE, 32'(`REQ_FULL), `RESP_OKAY);
    chk_mode(3'h1, 1'h1, 1'h1, 6'h0A);
    axi_wr(`OFF_MODE, 32'(`REQ_SLEEP), `RESP_OKAY);
    chk_mode(3'h1, 1'h1, 1'h1, 6'h0A);
    axi_wr(`OFF_PLL, {18'h0, m, 8'h00}, `RESP_OKAY);
    axi_wr(`OFF_MODE, 32'(`REQ_FULL), `RESP_OKAY);
    chk_mode(3'h0, 1'h0, 1'h0, m);
    chk(32'(pll_mult), 32'(m), "mult");
    $display("test bypass done");
    for (int s = 0; s < 2; s++) begin
      axi_wr(`OFF_PLL, {18'h0, m, 6'h0, s[0], 1'h0}, `RESP_OKAY);
      axi_wr(`OFF_MODE, 32'(`REQ_SLEEP), `RESP_OKAY);
      chk_mode(3'h2, 1'h0, 1'h0, m);
      chk(32'({dma_l1l2_en, dma_ext_en}), 32'h1, "sleep dma");
      axi_wr(`OFF_MODE, 32'(`REQ_FULL), `RESP_OKAY);
      chk_mode(3'h2, 1'h0, 1'h0, m);
      pulse(s[0]);
      chk_mode(3'(s), 1'h0, 1'h0, m);
    end
    $display("test sleep done");
    for (int s = 1; s >= 0; s--) begin
      axi_wr(`OFF_PLL, {18'h0, m, 6'h0, s[0], 1'h0}, `RESP_OKAY);
      axi_wr(`OFF_MODE, 32'(`REQ_DEEP), `RESP_OKAY);
      chk_mode(3'h3, 1'h0, 1'h0, m);
      chk(32'(async_periph_en), 32'h0, "async");
      pulse(1'h0);
      chk_mode(3'h3, 1'h0, 1'h0, m);
      pulse(1'h1);
      chk_mode(3'(s), 1'h0, 1'h0, m);
    end
    $display("test deep sleep done");
    rdc(`OFF_PLL, {18'h0, m, 8'h00}, `RESP_OKAY);
    axi_wr(`OFF_VREG, 32'h00000090, `RESP_OKAY);
    chk_mode(3'h4, 1'h0, 1'h0, m);
    pulse(1'h1);
    chk(32'({core_power_on, pins_hiz}), 32'h3, "restart");
    n = 0;
    while (boot_start !== 1'h1 && n < 3000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(32'(n), 32'(`SETTLE_NS / `CLK_PERIOD_NS - 2), "settle");
    chk_mode(3'h0, 1'h0, 1'h0, 6'h0A);
    rdc(`OFF_VREG, 32'h00000093, `RESP_OKAY);
    $display("test supply off done");
    test_done();
  end
endmodule

// File: core/power_mode_sequencer.sv
// Dynamic power mode sequencer with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "pwr_consts.svh"

module power_mode_sequencer
  import pwr_pkg::*;
(
  input  wire logic        clk_sys,          // System clock, 50 MHz
  input  wire logic        arst_n,           // Asynchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,     // Write address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output logic             s_axi_awready,    // Write address ready
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Write byte strobes
  input  wire logic        s_axi_wvalid,     // Write data valid
  output logic             s_axi_wready,     // Write data ready
  output logic [1:0]       s_axi_bresp,      // Write response
  output logic             s_axi_bvalid,     // Write response valid
  input  wire logic        s_axi_bready,     // Write response ready
  input  wire logic [7:0]  s_axi_araddr,     // Read address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output logic             s_axi_arready,    // Read address ready
  output logic [31:0]      s_axi_rdata,      // Read data
  output logic [1:0]       s_axi_rresp,      // Read response
  output logic             s_axi_rvalid,     // Read data valid
  input  wire logic        s_axi_rready,     // Read data ready
  input  wire logic        wakeup,           // External wakeup, level
  input  wire logic        reset_req,        // Reset interrupt / reset pin, level
  output logic             pll_enable,       // PLL powered
  output logic             pll_bypass,       // Clocks taken from the input clock
  output logic [5:0]       pll_mult,         // Multiplier applied to the PLL
  output logic             core_clk_en,      // Core clock gate
  output logic             sys_clk_en,       // System clock gate
  output logic             core_power_on,    // Internal regulator running
  output logic             regulator_bypass, // Regulator disabled and bypassed
  output logic [3:0]       vcore_level,      // Core voltage code, 50 mV per step
  output logic             dma_l1l2_en,      // DMA to on-chip memories allowed
  output logic             dma_ext_en,       // DMA to external memory allowed
  output logic             async_periph_en,  // Asynchronous peripheral access allowed
  output logic             pins_hiz,         // Three-state external pins
  output logic             boot_start        // One-cycle pulse starting boot
);

  // Regulator settle, a longest wait, so rounded down
  localparam int SETTLE_CYC_I = `SETTLE_NS / `CLK_PERIOD_NS;
  localparam logic [11:0] SETTLE_CYC = 12'(SETTLE_CYC_I);

  st_t s_reg;    // Registered state
  st_t s_next;   // Next state

  // Byte-lane merge of a write into an old register word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Current PLL control word as software sees it
  function automatic logic [31:0] pll_word(input st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`PLL_DIS_BIT] = s.pll_dis;
    r[`PLL_SKIP_BIT] = s.pll_skip;
    r[`PLL_MULT_LSB +: `PLL_MULT_W] = s.mult_req;
    return r;
  endfunction

  // Current regulator control word
  function automatic logic [31:0] vreg_word(input st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`VREG_FRQ_LSB +: 2] = s.vreg_frq;
    r[`VREG_LVL_LSB +: `VREG_LVL_W] = s.vreg_lvl;
    r[`VREG_BYP_BIT] = s.vreg_byp;
    return r;
  endfunction

  // Status word: mode, refusal flag and live multiplier
  function automatic logic [31:0] stat_word(input st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`STAT_MODE_LSB +: 3] = s.mode;
    r[`STAT_REFUSE_BIT] = s.refused;
    r[`STAT_MULT_LSB +: `PLL_MULT_W] = s.mult_act;
    return r;
  endfunction

  // Reset value of the whole state word
  function automatic st_t reset_state();
    st_t r;
    r = '0;
    r.mode = MODE_FULL;
    r.mult_req = `PLL_MULT_RST;
    r.mult_act = `PLL_MULT_RST;
    r.vreg_frq = `VREG_FRQ_RST;
    r.vreg_lvl = `VREG_LVL_RST;
    r.awready = 1'b1;
    r.wready = 1'b1;
    r.arready = 1'b1;
    r.pll_en = 1'b1;
    r.core_clk_en = 1'b1;
    r.sys_clk_en = 1'b1;
    r.core_pwr_on = 1'b1;
    r.dma_l1l2_en = 1'b1;
    r.dma_ext_en = 1'b1;
    r.async_en = 1'b1;
    return r;
  endfunction
  localparam st_t RESET_ST = reset_state();  // Constant word, so the async reset loads only constants

  // Next-state logic: bus slave, register writes, mode machine, outputs
  always_comb begin
    logic        do_wr;      // Both halves of a write are held
    logic [31:0] wv;         // Merged write value
    logic        req_v;      // Mode request written this cycle
    logic [1:0]  req_c;      // Requested mode code
    logic        off_v;      // Supply-off requested this cycle
    do_wr = 1'b0;
    wv = 32'h0000_0000;
    req_v = 1'b0;
    req_c = `REQ_FULL;
    off_v = 1'b0;
    s_next = s_reg;
    s_next.boot_start = 1'b0;

    // Capture write address and data in either order
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end

    // Response handed over, slot free again
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Perform a write once both halves are held and no response is pending
    do_wr = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
    if (do_wr) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `RESP_OKAY;
      case (s_reg.aw_addr)
        `OFF_PLL: begin
          wv = merge(pll_word(s_reg), s_reg.w_data, s_reg.w_strb);
          s_next.pll_skip = wv[`PLL_SKIP_BIT];
          // New multiplier is only stored, not applied yet
          s_next.mult_req = wv[`PLL_MULT_LSB +: `PLL_MULT_W];
          // PLL may only be switched off while bypassed
          if (s_reg.mode == MODE_BYPASS) begin
            s_next.pll_dis = wv[`PLL_DIS_BIT];
          end
        end
        `OFF_VREG: begin
          wv = merge(vreg_word(s_reg), s_reg.w_data, s_reg.w_strb);
          s_next.vreg_frq = wv[`VREG_FRQ_LSB +: 2];
          s_next.vreg_lvl = wv[`VREG_LVL_LSB +: `VREG_LVL_W];
          s_next.vreg_byp = wv[`VREG_BYP_BIT];
          off_v = (wv[`VREG_FRQ_LSB +: 2] == `VREG_FRQ_OFF);
        end
        `OFF_MODE: begin
          // Request is a command; the byte lane must be written
          req_v = s_reg.w_strb[0];
          req_c = s_reg.w_data[1:0];
        end
        `OFF_STAT: begin
          // Read-only, write ignored
        end
        default: begin
          s_next.bresp = `RESP_SLVERR;
        end
      endcase
    end

    // Read path: one-cycle answer, held until taken
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_reg.arready && s_axi_arvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `OFF_PLL:  s_next.rdata = pll_word(s_reg);
        `OFF_VREG: s_next.rdata = vreg_word(s_reg);
        `OFF_MODE: s_next.rdata = 32'h0000_0000;
        `OFF_STAT: s_next.rdata = stat_word(s_reg);
        default: begin
          s_next.rdata = 32'h0000_0000;
          s_next.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // Mode machine
    case (s_reg.mode)
      MODE_FULL, MODE_BYPASS: begin
        if (off_v) begin
          // Software must have saved state already; no check possible here
          s_next.mode = MODE_OFF;
        end else if (req_v) begin
          s_next.refused = 1'b0;
          case (req_c)
            `REQ_FULL: begin
              // A disabled PLL cannot feed full speed
              if (s_reg.pll_dis) begin
                s_next.refused = 1'b1;
              end else begin
                s_next.mode = MODE_FULL;
                s_next.mult_act = s_reg.mult_req;
              end
            end
            `REQ_BYPASS: s_next.mode = MODE_BYPASS;
            `REQ_SLEEP: begin
              if (s_reg.pll_dis) begin
                s_next.refused = 1'b1;
              end else begin
                s_next.mode = MODE_SLEEP;
              end
            end
            `REQ_DEEP: s_next.mode = MODE_DEEP;
            default: s_next.mode = s_reg.mode;
          endcase
        end
      end
      MODE_SLEEP: begin
        // Wakeup samples the skip bit to pick the resume mode
        if (wakeup || reset_req) begin
          if (s_reg.pll_skip) begin
            s_next.mode = MODE_BYPASS;
          end else begin
            s_next.mode = MODE_FULL;
            s_next.mult_act = s_reg.mult_req;
          end
        end
      end
      MODE_DEEP: begin
        // Wakeup is ignored here; only the reset interrupt exits
        if (reset_req) begin
          s_next.pll_dis = 1'b0;
          if (s_reg.pll_skip) begin
            s_next.mode = MODE_BYPASS;
          end else begin
            s_next.mode = MODE_FULL;
            s_next.mult_act = s_reg.mult_req;
          end
        end
      end
      MODE_OFF: begin
        // Only the reset pin brings the regulator back
        if (reset_req) begin
          s_next.mode = MODE_RESTART;
          s_next.settle = 12'h000;
          s_next.vreg_frq = `VREG_FRQ_RST;
        end
      end
      MODE_RESTART: begin
        // Wait for the core supply to settle, then boot at full speed
        if (s_reg.settle >= SETTLE_CYC - 12'h001) begin
          // Control state back to reset; a bus handshake in flight carries on untouched
          s_next.mode = RESET_ST.mode;
          s_next.pll_dis = RESET_ST.pll_dis;
          s_next.pll_skip = RESET_ST.pll_skip;
          s_next.mult_req = RESET_ST.mult_req;
          s_next.mult_act = RESET_ST.mult_act;
          s_next.vreg_frq = RESET_ST.vreg_frq;
          s_next.vreg_lvl = RESET_ST.vreg_lvl;
          s_next.vreg_byp = RESET_ST.vreg_byp;
          s_next.refused = RESET_ST.refused;
          s_next.boot_start = 1'b1;
        end else begin
          s_next.settle = s_reg.settle + 12'h001;
        end
      end
      default: s_next.mode = MODE_FULL;
    endcase

    // Bus readiness follows the held slots
    s_next.awready = !s_next.aw_full;
    s_next.wready = !s_next.w_full;
    s_next.arready = !s_next.rvalid;

    // Clock tree, supply and access outputs from the next mode
    s_next.pll_en = 1'b1;
    s_next.pll_byp = 1'b0;
    s_next.core_clk_en = 1'b1;
    s_next.sys_clk_en = 1'b1;
    s_next.core_pwr_on = 1'b1;
    s_next.dma_l1l2_en = 1'b1;
    s_next.dma_ext_en = 1'b1;
    s_next.async_en = 1'b1;
    s_next.pins_hiz = 1'b0;
    case (s_next.mode)
      MODE_FULL: begin
        // Everything on, PLL in the path
        s_next.pll_en = 1'b1;
      end
      MODE_BYPASS: begin
        // Clocks at input rate, PLL may be off by software
        s_next.pll_byp = 1'b1;
        s_next.pll_en = !s_next.pll_dis;
        s_next.dma_l1l2_en = 1'b1;
      end
      MODE_SLEEP: begin
        s_next.core_clk_en = 1'b0;
        s_next.dma_l1l2_en = 1'b0;
      end
      MODE_DEEP: begin
        s_next.pll_en = 1'b0;
        s_next.core_clk_en = 1'b0;
        s_next.sys_clk_en = 1'b0;
        s_next.dma_l1l2_en = 1'b0;
        s_next.dma_ext_en = 1'b0;
        s_next.async_en = 1'b0;
      end
      MODE_OFF, MODE_RESTART: begin
        // Core supply down in off, back on in restart; pins float so I/O neighbours draw no current
        s_next.pll_en = 1'b0;
        s_next.core_clk_en = 1'b0;
        s_next.sys_clk_en = 1'b0;
        s_next.core_pwr_on = (s_next.mode == MODE_RESTART);
        s_next.dma_l1l2_en = 1'b0;
        s_next.dma_ext_en = 1'b0;
        s_next.async_en = 1'b0;
        s_next.pins_hiz = 1'b1;
      end
      default: s_next.pins_hiz = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= RESET_ST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready    = s_reg.awready;
  assign s_axi_wready     = s_reg.wready;
  assign s_axi_bresp      = s_reg.bresp;
  assign s_axi_bvalid     = s_reg.bvalid;
  assign s_axi_arready    = s_reg.arready;
  assign s_axi_rdata      = s_reg.rdata;
  assign s_axi_rresp      = s_reg.rresp;
  assign s_axi_rvalid     = s_reg.rvalid;
  assign pll_enable       = s_reg.pll_en;
  assign pll_bypass       = s_reg.pll_byp;
  assign pll_mult         = s_reg.mult_act;
  assign core_clk_en      = s_reg.core_clk_en;
  assign sys_clk_en       = s_reg.sys_clk_en;
  assign core_power_on    = s_reg.core_pwr_on;
  assign regulator_bypass = s_reg.vreg_byp;
  assign vcore_level      = s_reg.vreg_lvl;
  assign dma_l1l2_en      = s_reg.dma_l1l2_en;
  assign dma_ext_en       = s_reg.dma_ext_en;
  assign async_periph_en  = s_reg.async_en;
  assign pins_hiz         = s_reg.pins_hiz;
  assign boot_start       = s_reg.boot_start;

endmodule

// File: core/pwr_consts.svh
// Register offsets, field positions, reset values and timing for the power mode sequencer
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH

// Register byte offsets
`define OFF_PLL         8'h00
`define OFF_VREG        8'h04
`define OFF_MODE        8'h08
`define OFF_STAT        8'h0C

// PLL control register fields
`define PLL_DIS_BIT     0
`define PLL_SKIP_BIT    1
`define PLL_MULT_LSB    8
`define PLL_MULT_W      6
`define PLL_MULT_RST    6'h0A

// Regulator control register fields
`define VREG_FRQ_LSB    0
`define VREG_FRQ_OFF    2'h0
`define VREG_FRQ_RST    2'h3
`define VREG_LVL_LSB    4
`define VREG_LVL_W      4
`define VREG_LVL_RST    4'h9
`define VREG_BYP_BIT    8

// Mode request codes, written to the mode register low bits
`define REQ_FULL        2'h0
`define REQ_BYPASS      2'h1
`define REQ_SLEEP       2'h2
`define REQ_DEEP        2'h3

// Status register fields
`define STAT_MODE_LSB   0
`define STAT_REFUSE_BIT 4
`define STAT_MULT_LSB   8

// Regulator settle time after restart, and the clock period
`define SETTLE_NS       40000
`define CLK_PERIOD_NS   20

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: core/pwr_pkg.sv
// Types shared by the power mode sequencer
package pwr_pkg;

  // Operating modes, the supply-off state and the regulator restart
  typedef enum logic [2:0] {
    MODE_FULL    = 3'b000,
    MODE_BYPASS  = 3'b001,
    MODE_SLEEP   = 3'b010,
    MODE_DEEP    = 3'b011,
    MODE_OFF     = 3'b100,
    MODE_RESTART = 3'b101
  } mode_t;

  // Whole state of the sequencer, registered as one word
  typedef struct packed {
    mode_t       mode;        // Current mode
    logic        pll_dis;     // PLL disable bit
    logic        pll_skip;    // PLL skip select bit
    logic [5:0]  mult_req;    // Multiplier written by software
    logic [5:0]  mult_act;    // Multiplier driven to the PLL
    logic [1:0]  vreg_frq;    // Regulator frequency field
    logic [3:0]  vreg_lvl;    // Core voltage level, 50 mV steps
    logic        vreg_byp;    // Regulator disabled and bypassed
    logic        refused;     // Last mode request refused
    logic [11:0] settle;      // Regulator settle counter
    logic        aw_full;     // Write address held
    logic [7:0]  aw_addr;     // Held write address
    logic        w_full;      // Write data held
    logic [31:0] w_data;      // Held write data
    logic [3:0]  w_strb;      // Held write strobes
    logic        awready;     // AXI outputs
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        pll_en;      // Clock tree, supply, access and boot outputs
    logic        pll_byp;
    logic        core_clk_en;
    logic        sys_clk_en;
    logic        core_pwr_on;
    logic        dma_l1l2_en;
    logic        dma_ext_en;
    logic        async_en;
    logic        pins_hiz;
    logic        boot_start;
  } st_t;

endpackage
